// ### src/dmr_pkg.sv
// constants, encodings and carrier types for the memory module host controller
// assumes a 50 MHz system clock and one memory module with a two-wire description store
package dmr_pkg;

	// memory command pins, sampled by the module on the rising edge of its clock
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} dmr_cmd_t;

	// access configuration written by software
	typedef struct packed {
		logic       fast;
		logic [1:0] bl;
	} dmr_cfg_t;

	// target location of one burst
	typedef struct packed {
		logic [1:0]  bank;
		logic [13:0] row;
		logic [11:0] col;
	} dmr_addr_t;

	typedef enum logic [3:0] {
		DMR_D_IDLE, DMR_D_MRS, DMR_D_GAP, DMR_D_ACT, DMR_D_RW,
		DMR_D_WSET, DMR_D_WDAT, DMR_D_RDAT, DMR_D_PRE
	} dmr_dstate_t;

	typedef enum logic [1:0] {DMR_K_START, DMR_K_BIT, DMR_K_STOP} dmr_sym_t;

	localparam dmr_cmd_t CMD_NOP   = 4'h7;
	localparam dmr_cmd_t CMD_ACT   = 4'h3;
	localparam dmr_cmd_t CMD_READ  = 4'h5;
	localparam dmr_cmd_t CMD_WRITE = 4'h4;
	localparam dmr_cmd_t CMD_PRE   = 4'h2;
	localparam dmr_cmd_t CMD_MRS   = 4'h0;

	// register byte addresses
	localparam logic [5:0] REG_CTRL     = 6'h00;
	localparam logic [5:0] REG_STATUS   = 6'h04;
	localparam logic [5:0] REG_CFG      = 6'h08;
	localparam logic [5:0] REG_ADDR     = 6'h0c;
	localparam logic [5:0] REG_BUF_IDX  = 6'h10;
	localparam logic [5:0] REG_BUF_LO   = 6'h14;
	localparam logic [5:0] REG_BUF_HI   = 6'h18;
	localparam logic [5:0] REG_SPD_IDX  = 6'h1c;
	localparam logic [5:0] REG_SPD_DATA = 6'h20;

	// control bits (write one to start; the write and auto-precharge bits only shape a memory start)
	localparam int CTRL_SPD_GO = 0;
	localparam int CTRL_MEM_GO = 1;
	localparam int CTRL_WRITE  = 2;
	localparam int CTRL_AUTOPRE = 3;

	localparam dmr_cfg_t CFG_RST = 3'h2;

	// description store layout
	localparam logic [6:0] SPD_DEV_ADDR = 7'h54;
	localparam int         SPD_LEN      = 64;
	localparam logic [5:0] SPD_TYPE     = 6'h02;
	localparam logic [5:0] SPD_BURSTS   = 6'h10;
	localparam logic [5:0] SPD_SUM      = 6'h3f;
	localparam logic [7:0] SPD_TYPE_DDR = 8'h07;

	// mode register read latency codes
	localparam logic [2:0] CL_SLOW = 3'h2;
	localparam logic [2:0] CL_FAST = 3'h3;

	// timing
	localparam int CLK_NS         = 20;
	localparam int I2C_QUARTER_NS = 625; // fast-mode rate keeps a full readout short
	localparam int I2C_Q_CYC      = (I2C_QUARTER_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] MRS_GAP_CK = 2'h2;
	localparam logic [1:0] PRE_GAP_CK = 2'h2;
	localparam logic [7:0] RD_TIMEOUT_CYC = 8'h40;

endpackage

// ### src/dmr_host.sv
// host controller for a double-data-rate memory module and its description store
// assumes open-drain pins resolved outside, Avalon-MM master on the register side
`timescale 1ns/1ps
module dmr_host (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic [5:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              scl_i,
	output logic                   scl_o,
	output logic                   scl_oe,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe,
	output logic                   ck,
	output logic                   ck_n,
	output logic                   cke,
	output dmr_pkg::dmr_cmd_t      cmd,
	output logic      [1:0]        ba,
	output logic      [13:0]       a,
	input  wire logic [63:0]       dq_i,
	output logic      [63:0]       dq_o,
	output logic                   dq_oe,
	input  wire logic [7:0]        dqs_i,
	output logic      [7:0]        dqs_o,
	output logic                   dqs_oe,
	output logic      [7:0]        dm
);

	// beats in a burst for a length code
	function automatic logic [3:0] beats(input logic [1:0] code);
		beats = 4'(4'h1 << code);
	endfunction

	logic [2:0]  sda_s, scl_s;
	logic [7:0]  dqs_s0, dqs_s1, dqs_s2;
	logic [63:0] dq_s0, dq_s1, dq_s2;
	logic        sda_lvl, scl_lvl;
	logic [31:0] next_rdata;
	logic        wr_en, spd_go, mem_go;
	dmr_pkg::dmr_cfg_t  cfg;
	dmr_pkg::dmr_addr_t maddr;
	logic [2:0]  buf_idx;
	logic [5:0]  spd_idx;
	logic [63:0] dbuf [8];
	logic [7:0]  spd_mem [dmr_pkg::SPD_LEN];
	logic        spd_busy, spd_done, spd_nack, sum_ok, type_ok;
	logic        mem_err, go_pend, go_write, go_ap;
	dmr_pkg::dmr_dstate_t dst, gap_to;
	logic [1:0]  ph, gap_cnt;
	logic        step, bl_ok;
	logic [3:0]  tog;
	logic [2:0]  widx;
	logic        rlvl;
	logic [7:0]  rto;
	logic        cap_we;
	logic [2:0]  cap_idx;
	logic [63:0] cap_word;
	dmr_pkg::dmr_sym_t kind;
	logic        i_act;
	logic [1:0]  q;
	logic [7:0]  qcnt;
	logic [3:0]  bitn;
	logic [7:0]  tx, rx, sum;
	logic [1:0]  stp;
	logic [5:0]  rcnt;
	logic        spd_we, tick, bit_val;

	// pin synchronisers; a level counts once the last two stages agree
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sda_s   <= 3'h7;
			scl_s   <= 3'h7;
			sda_lvl <= 1'b1;
			scl_lvl <= 1'b1;
			dqs_s0  <= 8'h00;
			dqs_s1  <= 8'h00;
			dqs_s2  <= 8'h00;
			dq_s0   <= 64'h0;
			dq_s1   <= 64'h0;
			dq_s2   <= 64'h0;
		end else begin
			sda_s  <= {sda_s[1:0], sda_i};
			scl_s  <= {scl_s[1:0], scl_i};
			dqs_s0 <= dqs_i;
			dqs_s1 <= dqs_s0;
			dqs_s2 <= dqs_s1;
			dq_s0  <= dq_i;
			dq_s1  <= dq_s0;
			dq_s2  <= dq_s1;
			if (sda_s[1] == sda_s[2])
				sda_lvl <= sda_s[2];
			if (scl_s[1] == scl_s[2])
				scl_lvl <= scl_s[2];
		end
	end

	// bus slave: one wait cycle, then the answer stands for one edge
	assign wr_en  = avs_write && !avs_waitrequest;
	assign spd_go = wr_en && avs_address == dmr_pkg::REG_CTRL
		&& avs_writedata[dmr_pkg::CTRL_SPD_GO];
	assign mem_go = wr_en && avs_address == dmr_pkg::REG_CTRL
		&& avs_writedata[dmr_pkg::CTRL_MEM_GO];
	assign bl_ok  = cfg.bl != 2'h0 && spd_mem[dmr_pkg::SPD_BURSTS][cfg.bl];

	always_comb begin
		next_rdata = 32'h0;
		if (avs_address == dmr_pkg::REG_STATUS)
			next_rdata = {25'h0, mem_err, go_pend || dst != dmr_pkg::DMR_D_IDLE,
				type_ok, sum_ok, spd_nack, spd_done, spd_busy};
		else if (avs_address == dmr_pkg::REG_CFG)
			next_rdata = {29'h0, cfg};
		else if (avs_address == dmr_pkg::REG_ADDR)
			next_rdata = {4'h0, maddr};
		else if (avs_address == dmr_pkg::REG_BUF_IDX)
			next_rdata = {29'h0, buf_idx};
		else if (avs_address == dmr_pkg::REG_BUF_LO)
			next_rdata = dbuf[buf_idx][31:0];
		else if (avs_address == dmr_pkg::REG_BUF_HI)
			next_rdata = dbuf[buf_idx][63:32];
		else if (avs_address == dmr_pkg::REG_SPD_IDX)
			next_rdata = {26'h0, spd_idx};
		else if (avs_address == dmr_pkg::REG_SPD_DATA)
			next_rdata = {24'h0, spd_mem[spd_idx]};
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0;
		end else if (avs_waitrequest && (avs_read || avs_write)) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= next_rdata;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// software settings
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg     <= dmr_pkg::CFG_RST;
			maddr   <= '0;
			buf_idx <= 3'h0;
			spd_idx <= 6'h00;
		end else if (wr_en) begin
			if (avs_address == dmr_pkg::REG_CFG)
				cfg <= avs_writedata[2:0];
			else if (avs_address == dmr_pkg::REG_ADDR)
				maddr <= avs_writedata[27:0];
			else if (avs_address == dmr_pkg::REG_BUF_IDX)
				buf_idx <= avs_writedata[2:0];
			else if (avs_address == dmr_pkg::REG_SPD_IDX)
				spd_idx <= avs_writedata[5:0];
		end
	end

	// burst buffer; captured read beats take priority over a bus write
	always_ff @(posedge clk) begin
		if (cap_we)
			dbuf[cap_idx] <= cap_word;
		else if (wr_en && avs_address == dmr_pkg::REG_BUF_LO)
			dbuf[buf_idx][31:0] <= avs_writedata;
		else if (wr_en && avs_address == dmr_pkg::REG_BUF_HI)
			dbuf[buf_idx][63:32] <= avs_writedata;
	end

	// module clock: four system clocks per period, high in phases 0 and 1
	assign step = ph == 2'h1;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ph   <= 2'h2; // start in the low half, so no short first pulse
			ck   <= 1'b0;
			ck_n <= 1'b1;
			cke  <= 1'b0;
			dm   <= 8'h00;
		end else begin
			ph   <= ph + 2'h1;
			ck   <= ph == 2'h3 || ph == 2'h0;
			ck_n <= !(ph == 2'h3 || ph == 2'h0);
			cke  <= 1'b1;
			dm   <= 8'h00;
		end
	end

	// memory access sequencer; commands update at phase 1 and show from the clock fall
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dst <= dmr_pkg::DMR_D_IDLE;
			gap_to <= dmr_pkg::DMR_D_IDLE;
			gap_cnt <= 2'h0;
			cmd <= dmr_pkg::CMD_NOP;
			ba <= 2'h0;
			a <= 14'h0;
			go_pend <= 1'b0;
			go_write <= 1'b0;
			go_ap <= 1'b0;
			mem_err <= 1'b0;
			dq_o <= 64'h0;
			dq_oe <= 1'b0;
			dqs_o <= 8'h00;
			dqs_oe <= 1'b0;
			tog <= 4'h0;
			widx <= 3'h0;
			rlvl <= 1'b0;
			rto <= 8'h00;
			cap_we <= 1'b0;
			cap_idx <= 3'h0;
			cap_word <= 64'h0;
		end else begin
			cap_we <= 1'b0;
			// refuse use before a checked store or with a length it does not allow
			if (mem_go && !go_pend && dst == dmr_pkg::DMR_D_IDLE) begin
				if (spd_done && sum_ok && type_ok && bl_ok) begin
					go_pend  <= 1'b1;
					go_write <= avs_writedata[dmr_pkg::CTRL_WRITE];
					go_ap    <= avs_writedata[dmr_pkg::CTRL_AUTOPRE];
					mem_err  <= 1'b0;
				end else begin
					mem_err <= 1'b1;
				end
			end
			if (step)
				cmd <= dmr_pkg::CMD_NOP;
			case (dst)
			dmr_pkg::DMR_D_IDLE: if (step && go_pend) begin
				go_pend <= 1'b0;
				cmd <= dmr_pkg::CMD_MRS;
				ba <= 2'h0;
				a <= {7'h0, cfg.fast ? dmr_pkg::CL_FAST : dmr_pkg::CL_SLOW, 1'b0, 1'b0, cfg.bl};
				gap_cnt <= dmr_pkg::MRS_GAP_CK;
				gap_to <= dmr_pkg::DMR_D_ACT;
				dst <= dmr_pkg::DMR_D_GAP;
			end
			dmr_pkg::DMR_D_GAP: if (step) begin
				if (gap_cnt == 2'h0)
					dst <= gap_to;
				else
					gap_cnt <= gap_cnt - 2'h1;
			end
			dmr_pkg::DMR_D_ACT: if (step) begin
				cmd <= dmr_pkg::CMD_ACT;
				ba <= maddr.bank;
				a <= maddr.row;
				dst <= dmr_pkg::DMR_D_RW;
			end
			dmr_pkg::DMR_D_RW: if (step) begin
				cmd <= go_write ? dmr_pkg::CMD_WRITE : dmr_pkg::CMD_READ;
				ba <= maddr.bank;
				a <= {1'b0, maddr.col[11:10], go_ap, maddr.col[9:0]};
				dst <= go_write ? dmr_pkg::DMR_D_WSET : dmr_pkg::DMR_D_RDAT;
				tog <= 4'h0;
				rlvl <= 1'b0;
				rto <= 8'h00;
			end
			// preamble: strobe driven low, first word on the bus
			dmr_pkg::DMR_D_WSET: if (step) begin
				dqs_oe <= 1'b1;
				dqs_o <= 8'h00;
				dq_oe <= 1'b1;
				dq_o <= dbuf[0];
				widx <= 3'h1;
				dst <= dmr_pkg::DMR_D_WDAT;
			end
			// strobe toggles in even phases, data moves in odd ones: centred edges
			dmr_pkg::DMR_D_WDAT: begin
				if (!ph[0]) begin
					if (tog == beats(cfg.bl)) begin
						dqs_oe <= 1'b0;
						dq_oe <= 1'b0;
						gap_cnt <= dmr_pkg::PRE_GAP_CK;
						gap_to <= go_ap ? dmr_pkg::DMR_D_IDLE : dmr_pkg::DMR_D_PRE;
						dst <= dmr_pkg::DMR_D_GAP;
					end else begin
						dqs_o <= ~dqs_o;
						tog <= tog + 4'h1;
					end
				end else if (tog != beats(cfg.bl)) begin
					dq_o <= dbuf[widx];
					widx <= widx + 3'h1;
				end
			end
			// each settled strobe edge takes one word; a silent module times out
			dmr_pkg::DMR_D_RDAT: begin
				rto <= rto + 8'h01;
				if (dqs_s1[0] == dqs_s2[0] && dqs_s2[0] != rlvl) begin
					rlvl <= dqs_s2[0];
					cap_we <= 1'b1;
					cap_idx <= tog[2:0];
					cap_word <= dq_s2;
					tog <= tog + 4'h1;
				end
				if (tog == beats(cfg.bl) || rto == dmr_pkg::RD_TIMEOUT_CYC) begin
					mem_err <= rto == dmr_pkg::RD_TIMEOUT_CYC;
					gap_cnt <= dmr_pkg::PRE_GAP_CK;
					gap_to <= go_ap ? dmr_pkg::DMR_D_IDLE : dmr_pkg::DMR_D_PRE;
					dst <= dmr_pkg::DMR_D_GAP;
				end
			end
			dmr_pkg::DMR_D_PRE: if (step) begin
				cmd <= dmr_pkg::CMD_PRE;
				ba <= maddr.bank;
				a <= 14'h0;
				gap_cnt <= dmr_pkg::PRE_GAP_CK;
				gap_to <= dmr_pkg::DMR_D_IDLE;
				dst <= dmr_pkg::DMR_D_GAP;
			end
			default: dst <= dmr_pkg::DMR_D_IDLE;
			endcase
		end
	end

	// two-wire bit driven in the current bit symbol; receiving means release
	always_comb begin
		bit_val = 1'b1;
		if (bitn < 4'h8)
			bit_val = stp == 2'h3 ? 1'b1 : tx[7];
		else if (stp == 2'h3)
			bit_val = rcnt == 6'(dmr_pkg::SPD_LEN - 1);
	end
	assign tick   = qcnt == 8'(dmr_pkg::I2C_Q_CYC - 1);
	assign spd_we = i_act && tick && kind == dmr_pkg::DMR_K_BIT && q == 2'h3
		&& bitn == 4'h8 && stp == 2'h3;

	always_ff @(posedge clk) begin
		if (spd_we)
			spd_mem[rcnt] <= rx;
	end

	// store reader: address write of byte 0, repeated start, sequential read of the first 64 bytes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			i_act <= 1'b0;
			kind <= dmr_pkg::DMR_K_STOP;
			q <= 2'h0;
			qcnt <= 8'h00;
			bitn <= 4'h0;
			tx <= 8'h00;
			rx <= 8'h00;
			sum <= 8'h00;
			stp <= 2'h0;
			rcnt <= 6'h00;
			spd_busy <= 1'b0;
			spd_done <= 1'b0;
			spd_nack <= 1'b0;
			sum_ok <= 1'b0;
			type_ok <= 1'b0;
		end else if (!i_act) begin
			qcnt <= 8'h00;
			if (spd_go) begin
				i_act <= 1'b1;
				kind <= dmr_pkg::DMR_K_START;
				q <= 2'h0;
				tx <= {dmr_pkg::SPD_DEV_ADDR, 1'b0};
				stp <= 2'h0;
				rcnt <= 6'h00;
				sum <= 8'h00;
				spd_busy <= 1'b1;
				spd_done <= 1'b0;
				spd_nack <= 1'b0;
			end
		end else if (q == 2'h2 && !scl_lvl && kind != dmr_pkg::DMR_K_START) begin
			qcnt <= 8'h00; // a stretched clock holds the high half back
		end else if (!tick) begin
			qcnt <= qcnt + 8'h01;
		end else begin
			qcnt <= 8'h00;
			q <= q + 2'h1;
			if (kind == dmr_pkg::DMR_K_BIT && q == 2'h2) begin
				if (bitn < 4'h8)
					rx <= {rx[6:0], sda_lvl};
				else if (stp != 2'h3 && sda_lvl)
					spd_nack <= 1'b1;
			end
			if (q == 2'h3) begin
				case (kind)
				dmr_pkg::DMR_K_START: begin
					kind <= dmr_pkg::DMR_K_BIT;
					bitn <= 4'h0;
				end
				dmr_pkg::DMR_K_STOP: begin
					i_act <= 1'b0;
					spd_busy <= 1'b0;
					spd_done <= !spd_nack;
					sum_ok <= sum == spd_mem[dmr_pkg::SPD_SUM];
					type_ok <= spd_mem[dmr_pkg::SPD_TYPE] == dmr_pkg::SPD_TYPE_DDR;
				end
				default: if (bitn < 4'h8) begin
					bitn <= bitn + 4'h1;
					tx <= {tx[6:0], 1'b0};
				end else begin
					bitn <= 4'h0;
					if (stp != 2'h3 && spd_nack) begin
						kind <= dmr_pkg::DMR_K_STOP;
					end else if (stp == 2'h0) begin
						stp <= 2'h1;
						tx <= 8'h00;
					end else if (stp == 2'h1) begin
						stp <= 2'h2;
						kind <= dmr_pkg::DMR_K_START;
						tx <= {dmr_pkg::SPD_DEV_ADDR, 1'b1};
					end else if (stp == 2'h2) begin
						stp <= 2'h3;
					end else begin
						rcnt <= rcnt + 6'h01;
						if (rcnt != dmr_pkg::SPD_SUM)
							sum <= sum + rx;
						if (rcnt == 6'(dmr_pkg::SPD_LEN - 1))
							kind <= dmr_pkg::DMR_K_STOP;
					end
				end
				endcase
			end
		end
	end

	// open-drain drive: low or released only, data moves while the clock is low
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			scl_o  <= 1'b0;
			sda_o  <= 1'b0;
		end else begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			if (!i_act) begin
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
			end else if (kind == dmr_pkg::DMR_K_START) begin
				scl_oe <= q == 2'h0 || q == 2'h3;
				sda_oe <= q[1];
			end else if (kind == dmr_pkg::DMR_K_BIT) begin
				scl_oe <= q == 2'h0 || q == 2'h3;
				sda_oe <= !bit_val;
			end else begin
				scl_oe <= q == 2'h0;
				sda_oe <= !q[1];
			end
		end
	end

endmodule // dmr_host

// ### tb/dmr_host_checker.sv
// port assertions for the memory module host controller
// assumes a bind into dmr_host and the single system clock domain
`timescale 1ns/1ps
module dmr_host_checker (
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic              avs_waitrequest,
	input wire logic              scl_o,
	input wire logic              sda_o,
	input wire logic              ck,
	input wire logic              ck_n,
	input wire dmr_pkg::dmr_cmd_t cmd,
	input wire logic [13:0]       a,
	input wire logic [63:0]       dq_o,
	input wire logic              dq_oe,
	input wire logic [7:0]        dqs_o,
	input wire logic              dqs_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// one answer cycle per request, then idle again
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing wrong");
	// module clock pair: complementary, four system clocks per period
	ck_pair_a: assert property (ck_n == !ck) else $error("clock pair not complementary");
	ck_rate_a: assert property ($rose(ck) |=> ck ##1 !ck ##1 !ck ##1 ck)
		else $error("module clock period wrong");
	// commands settle at the fall so the rise takes them cleanly
	cmd_fall_a: assert property ($changed(cmd) |-> $fell(ck))
		else $error("command moved off the clock fall");
	act_first_a: assert property ($changed(cmd) && (cmd == dmr_pkg::CMD_READ ||
		cmd == dmr_pkg::CMD_WRITE) |-> $past(cmd) == dmr_pkg::CMD_ACT)
		else $error("access without row open");
	mode_code_a: assert property (cmd == dmr_pkg::CMD_MRS |->
		a[2:0] inside {3'h1, 3'h2, 3'h3} && a[6:4] inside {3'h2, 3'h3})
		else $error("mode register code out of range");
	// strobe and data are driven together, only in write bursts
	strobe_own_a: assert property (dqs_oe == dq_oe) else $error("strobe enable mismatch");
	strobe_mid_a: assert property (dqs_oe && $past(dqs_oe) && $changed(dq_o) |->
		$stable(dqs_o)) else $error("strobe moved with write data");
	wdata_start_a: assert property ($changed(cmd) && cmd == dmr_pkg::CMD_WRITE |->
		##4 $rose(dqs_oe)) else $error("write data not one module clock after command");
	wire_low_a: assert property (!scl_o && !sda_o) else $error("serial line driven high");
endmodule // dmr_host_checker

bind dmr_host dmr_host_checker u_chk (.clk(clk), .rstn(rstn), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .scl_o(scl_o), .sda_o(sda_o),
	.ck(ck), .ck_n(ck_n), .cmd(cmd), .a(a), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o),
	.dqs_oe(dqs_oe));

// ### tb/dmr_mod_model.sv
// behavioural memory module: command decode, read bursts, write capture, description store
// assumes the bench resolves both serial lines with pull-ups
`timescale 1ns/1ps
module dmr_mod_model #(
	parameter logic [7:0] MAKER = 8'h5e // arbitrary value
) (
	input  wire logic              ck,
	input  wire dmr_pkg::dmr_cmd_t cmd,
	input  wire logic [1:0]        ba,
	input  wire logic [13:0]       a,
	input  wire logic [63:0]       dq_o,
	input  wire logic              dqs_oe,
	input  wire logic [7:0]        dqs_o,
	output logic      [63:0]       dq_i,
	output logic      [7:0]        dqs_i,
	input  wire logic              scl,
	input  wire logic              sda,
	output logic                   pull
);
	logic [7:0]  mem [0:255];
	logic [63:0] wr_q [0:7];
	logic [7:0]  sh, ptr, sum;
	logic [6:0]  own;
	logic [1:0]  bank;
	logic [11:0] col;
	logic        ap;
	int          bl, cl, wn, pre_n, cnt, ph;

	// filler, fixed fields, then the sum over bytes 0..62
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i * 7 + 1);
		mem[2] = 8'h07;
		mem[3] = 8'h0d;
		mem[4] = 8'h0a;
		mem[5] = 8'h01;
		mem[16] = 8'h06; // lengths 2 and 4 only
		mem[17] = 8'h04;
		mem[64] = MAKER;
		mem[93] = 8'h25;
		sum = 8'h0;
		for (int i = 0; i < 63; i++)
			sum = sum + mem[i];
		mem[63] = sum;
		own = dmr_pkg::SPD_DEV_ADDR; // low bits 100
		pull = 1'h0;
		dqs_i = 8'h0;
		dq_i = 64'h0;
		{ph, pre_n, wn, bl, cl} = {32'h0, 32'h0, 32'h0, 32'h2, 32'h2};
	end

	// commands taken on the rising module clock only
	always @(posedge ck) begin
		if (cmd == dmr_pkg::CMD_MRS) begin
			bl = 1 << a[2:0];
			cl = int'(a[6:4]);
		end
		if (cmd == dmr_pkg::CMD_PRE)
			pre_n++;
		if (cmd == dmr_pkg::CMD_READ || cmd == dmr_pkg::CMD_WRITE) begin
			bank = ba;
			col = {a[12:11], a[9:0]};
			ap = a[10]; // self-timed precharge, no command needed
			wn = 0;
		end
		if (cmd == dmr_pkg::CMD_READ)
			fork
				burst();
			join_none
	end

	// beats edge-aligned with the strobe, counting up from the start column
	task automatic burst();
		repeat (cl) @(posedge ck);
		for (int n = 0; n < bl; n++) begin
			dq_i = {bank, 50'h0, col + 12'(n)};
			dqs_i = n[0] ? 8'h00 : 8'hff;
			@(ck);
		end
		dq_i = ~dq_i; // released bus must not keep the last beat
	endtask

	// write beats taken on both strobe edges while the host drives it
	always @(dqs_o[0]) if (dqs_oe) begin
		wr_q[wn % 8] = dq_o;
		wn++;
	end

	// start and stop: data moving while the serial clock is high
	always @(negedge sda) if (scl === 1'h1) begin
		cnt = -1;
		ph = 1;
		pull = 1'h0;
	end
	always @(posedge sda) if (scl === 1'h1) begin
		ph = 0;
		pull = 1'h0;
	end

	// eight bits in, or the ninth clock sampled for the host's answer
	always @(posedge scl) begin
		if (cnt < 8)
			sh = {sh[6:0], sda};
		else if (ph == 3 && sda)
			ph = 0;
	end

	// drive only while the clock is low; phases: 1 address, 2 word, 3 read, 4 wait
	always @(negedge scl) if (ph != 0) begin
		if (cnt == 8) begin
			cnt = 0;
			pull = 1'h0;
			if (ph == 3)
				ptr++;
			if (ph == 1)
				ph = sh[0] ? 3 : 2;
			else if (ph == 2)
				ph = 4;
		end else
			cnt++;
		if (cnt == 8 && ph == 1) begin
			pull = (sh[7:1] == own);
			if (!pull)
				ph = 0;
		end
		if (cnt == 8 && ph == 2) begin
			pull = 1'h1;
			ptr = sh;
		end
		if (ph == 3)
			pull = (cnt < 8) && !mem[ptr][7 - cnt];
	end
endmodule // dmr_mod_model

// ### tb/testbench.sv
// self-checking bench: registers, description store readout, write and read bursts
// assumes the behavioural module model on the far side, pull-ups on the serial lines
`timescale 1ns/1ps
module testbench;
	logic              clk, rstn, avs_read, avs_write, avs_waitrequest;
	logic              scl_o, scl_oe, sda_o, sda_oe, pull, scl_w, sda_w;
	logic              ck, ck_n, cke, dq_oe, dqs_oe;
	logic [5:0]        avs_address;
	logic [31:0]       avs_writedata, avs_readdata, rdata;
	logic [1:0]        ba;
	logic [13:0]       a;
	logic [63:0]       dq_i, dq_o;
	logic [7:0]        dqs_i, dqs_o, dm;
	dmr_pkg::dmr_cmd_t cmd;
	int                err_count, check_count;

	// released lines read high through the pull-ups
	assign scl_w = !scl_oe;
	assign sda_w = !(sda_oe || pull);

	dmr_host u_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .ck(ck), .ck_n(ck_n), .cke(cke),
		.cmd(cmd), .ba(ba), .a(a), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_i(dqs_i),
		.dqs_o(dqs_o), .dqs_oe(dqs_oe), .dm(dm));
	dmr_mod_model u_mod (.ck(ck), .cmd(cmd), .ba(ba), .a(a), .dq_o(dq_o), .dqs_oe(dqs_oe),
		.dqs_o(dqs_o), .dq_i(dq_i), .dqs_i(dqs_i), .scl(scl_w), .sda(sda_w), .pull(pull));

	// 50 MHz system clock
	always #10 clk = ~clk;

	// compare and count
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= ad;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'h0);
		rdata = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge clk);
		if (n >= 50)
			chk("bus answer", 64'h1, 64'h0);
	endtask

	// poll the status word until one bit clears; leaves the last status in rdata
	task automatic wait_clr(input int b, input int lim);
		int n;
		n = 0;
		do begin
			bus(1'h0, dmr_pkg::REG_STATUS, 32'h0);
			n++;
		end while (rdata[b] !== 1'h0 && n < lim);
		chk("busy clears", 64'(rdata[b]), 64'h0);
	endtask

	// reset values, read back, unmapped place, access before the store is read
	task automatic t_regs();
		bus(1'h0, dmr_pkg::REG_CFG, 32'h0);
		chk("cfg reset", 64'(rdata), 64'h2);
		chk("clock enable", 64'(cke), 64'h1);
		bus(1'h1, dmr_pkg::REG_ADDR, 32'h0abc_1234);
		bus(1'h0, dmr_pkg::REG_ADDR, 32'h0);
		chk("addr rw", 64'(rdata), 64'h0abc_1234);
		bus(1'h1, 6'h3c, 32'hffff_ffff);
		bus(1'h0, 6'h3c, 32'h0);
		chk("unmapped", 64'(rdata), 64'h0);
		bus(1'h1, dmr_pkg::REG_CTRL, 32'h2);
		wait_clr(5, 100);
		chk("early access", 64'(rdata[6]), 64'h1);
		$display("test regs done");
	endtask

	// store at another address first, then the real readout of 64 bytes
	task automatic t_store();
		u_mod.own = 7'h55;
		bus(1'h1, dmr_pkg::REG_CTRL, 32'h1);
		wait_clr(0, 200000);
		chk("nack flags", 64'(rdata[2:1]), 64'h2);
		u_mod.own = dmr_pkg::SPD_DEV_ADDR;
		bus(1'h1, dmr_pkg::REG_CTRL, 32'h1);
		wait_clr(0, 200000);
		chk("store flags", 64'(rdata[4:1]), 64'hd);
		chk("store idle", 64'(u_mod.ph), 64'h0);
		for (int i = 0; i < 64; i++) begin
			bus(1'h1, dmr_pkg::REG_SPD_IDX, 32'(i));
			bus(1'h0, dmr_pkg::REG_SPD_DATA, 32'h0);
			chk("store byte", 64'(rdata), 64'(u_mod.mem[i]));
		end
		$display("test store done");
	endtask

	// burst length of 8 is not offered by the store
	task automatic t_len();
		bus(1'h1, dmr_pkg::REG_CFG, 32'h3);
		bus(1'h1, dmr_pkg::REG_CTRL, 32'h2);
		wait_clr(5, 100);
		chk("length refused", 64'(rdata[6]), 64'h1);
		$display("test length done");
	endtask

	// four-beat write with auto-precharge, upper column bits in use
	task automatic t_write();
		int p;
		p = u_mod.pre_n;
		bus(1'h1, dmr_pkg::REG_CFG, 32'h2);
		for (int i = 0; i < 4; i++) begin
			bus(1'h1, dmr_pkg::REG_BUF_IDX, 32'(i));
			bus(1'h1, dmr_pkg::REG_BUF_LO, 32'h0f0f_0000 + 32'(i));
			bus(1'h1, dmr_pkg::REG_BUF_HI, 32'ha5a5_0000 + 32'(i));
		end
		bus(1'h1, dmr_pkg::REG_ADDR, {4'h0, 2'h1, 14'h0005, 12'h810});
		bus(1'h1, dmr_pkg::REG_CTRL, 32'he);
		wait_clr(5, 200);
		chk("write error", 64'(rdata[6]), 64'h0);
		for (int i = 0; i < 4; i++)
			chk("write beat", u_mod.wr_q[i], {32'ha5a5_0000 + 32'(i), 32'h0f0f_0000 + 32'(i)});
		chk("write beats", 64'(u_mod.wn), 64'h4);
		chk("bank col", 64'({u_mod.bank, u_mod.col}), 64'h1810);
		chk("auto precharge", 64'({u_mod.ap, 32'(u_mod.pre_n - p)}), 64'h1_0000_0000);
		chk("mask", 64'(dm), 64'h0);
		$display("test write done");
	endtask

	// two-beat read at the fast latency, then a separate precharge
	task automatic t_read();
		logic [31:0] lo;
		int          p;
		p = u_mod.pre_n;
		bus(1'h1, dmr_pkg::REG_CFG, 32'h5);
		bus(1'h1, dmr_pkg::REG_ADDR, {4'h0, 2'h2, 14'h0003, 12'habc});
		bus(1'h1, dmr_pkg::REG_CTRL, 32'h2);
		wait_clr(5, 200);
		chk("read error", 64'(rdata[6]), 64'h0);
		chk("latency", 64'(u_mod.cl), 64'h3);
		for (int i = 0; i < 2; i++) begin
			bus(1'h1, dmr_pkg::REG_BUF_IDX, 32'(i));
			bus(1'h0, dmr_pkg::REG_BUF_LO, 32'h0);
			lo = rdata;
			bus(1'h0, dmr_pkg::REG_BUF_HI, 32'h0);
			chk("read beat", {rdata, lo}, {2'h2, 50'h0, 12'habc + 12'(i)});
		end
		chk("precharge", 64'(u_mod.pre_n - p), 64'h1);
		$display("test read done");
	endtask

	// counts, verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		{clk, rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
		repeat (20) @(posedge clk);
		rstn <= 1'h1;
		t_regs();
		t_store();
		t_write();
		t_len();
		t_read();
		end_of_test();
	end

	// the store readout alone takes about 78k cycles
	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		end_of_test();
	end
endmodule // testbench
